// File: rtl/amc_pkg.sv
// package: constants and carriers for the async mram host controller
package amc_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned ADDR_W        = 18;
   localparam int unsigned DATA_W        = 16;
   // timing figures in ns
   localparam int unsigned T_CYCLE_NS      = 35;
   localparam int unsigned T_ACCESS_NS     = 35;
   localparam int unsigned T_OE_ACCESS_NS  = 15;
   localparam int unsigned T_STROBE_NS     = 15;
   localparam int unsigned T_DATA_SETUP_NS = 10;
   localparam int unsigned T_RECOVERY_NS   = 12;
   localparam int unsigned T_FLOAT_NS      = 15;
   localparam int unsigned T_HIGH_NS       = 2;
   localparam int unsigned T_POWERUP_NS    = 2000000;
   // derived cycle counts: least times round up
   localparam int unsigned CYC_CYCLE    = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CYC_ACCESS   = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CYC_STROBE   = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CYC_RECOVERY = (T_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CYC_FLOAT    = (T_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CYC_HIGH     = (T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CYC_POWERUP  = (T_POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W        = 18;
   localparam logic [15:0] DATA_RST     = 16'h0000;
   localparam logic [17:0] ADDR_RST     = 18'h0_0000;

   typedef struct packed {
      logic        write;
      logic [1:0]  lanes;
      logic [17:0] addr;
      logic [15:0] wdata;
   } amc_req_t;

   typedef struct packed {
      logic        chip_sel_n;
      logic        wr_strobe_n;
      logic        out_en_n;
      logic        high_lane_select_n;
      logic        low_lane_select_n;
   } amc_ctl_t;

   typedef enum logic [2:0] {
      AMC_POWERUP = 3'b000,
      AMC_IDLE    = 3'b001,
      AMC_RD      = 3'b010,
      AMC_WR      = 3'b011,
      AMC_WREC    = 3'b100,
      AMC_FLOAT   = 3'b101,
      AMC_GAP     = 3'b110
   } amc_state_t;
endpackage : amc_pkg

// File: rtl/amc_counter.sv
// down counter used for every timed phase of the host controller
`timescale 1ns/1ps
module amc_counter #(
   parameter int unsigned WIDTH = 18
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             ce,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] load_val,
   output logic                  zero
);
   logic [WIDTH-1:0] cnt_r;
   logic [WIDTH-1:0] cnt_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      if (load) begin
         cnt_nxt = load_val;
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_r <= '0;
      end else if (ce) begin
         cnt_r <= cnt_nxt;
      end
   end

   assign zero = (cnt_r == '0);
endmodule : amc_counter

// File: rtl/amc_host.sv
// host controller driving an asynchronous 256k x 16 mram over its pins
// Function
// - write strobe stays high throughout every read cycle.
// - host holds write overlap low at least 15 ns.
// - host sets data 10 ns before write end, holds 0 ns after.
// - address valid 18 ns before write end, setup 0 ns.
// - chip select assertions spaced at least 35 ns apart.
// - raised strobe, select or lane select stays high 2 ns.
// - address held 12 ns after write end before changing.
// - both lane selects switch together within 2 ns skew.
// - chip select and strobe high 2 ms after power-up.
`timescale 1ns/1ps
module amc_host #(
   parameter int unsigned POWERUP_CYCLES = amc_pkg::CYC_POWERUP
) (
   input  wire logic                clk,
   input  wire logic                reset,
   input  wire logic                ce,
   input  wire amc_pkg::amc_req_t   req,
   input  wire logic                req_valid,
   output logic                     req_ready,
   output logic [15:0]              rd_data,
   output logic                     rd_valid,
   output logic                     wr_done,
   output logic [17:0]              mem_addr,
   output amc_pkg::amc_ctl_t        mem_ctl,
   input  wire logic [15:0]         mem_dq_in,
   output logic [15:0]              mem_dq_out,
   output logic                     mem_dq_oe
);
   amc_pkg::amc_state_t state_r, state_nxt;
   amc_pkg::amc_ctl_t   ctl_r, ctl_nxt;
   amc_pkg::amc_req_t   cur_r, cur_nxt;
   logic [17:0]         addr_r, addr_nxt;
   logic [15:0]         dq_out_r, dq_out_nxt;
   logic                dq_oe_r, dq_oe_nxt;
   logic [15:0]         rdata_r, rdata_nxt;
   logic                rvalid_r, rvalid_nxt;
   logic                wdone_r, wdone_nxt;
   logic                ready_r, ready_nxt;
   logic                ld;
   logic [17:0]         ld_val;
   logic                tmr_zero;
   logic                pu_load_r;

   localparam amc_pkg::amc_ctl_t CTL_IDLE = 5'h1F;

   amc_counter #(
      .WIDTH    (amc_pkg::CNT_W)
   ) u_tmr (
      .clk      (clk),
      .reset    (reset),
      .ce       (ce),
      .load     (ld),
      .load_val (ld_val),
      .zero     (tmr_zero)
   );

   always_comb begin
      state_nxt  = state_r;
      ctl_nxt    = ctl_r;
      cur_nxt    = cur_r;
      addr_nxt   = addr_r;
      dq_out_nxt = dq_out_r;
      dq_oe_nxt  = dq_oe_r;
      rdata_nxt  = rdata_r;
      rvalid_nxt = 1'b0;
      wdone_nxt  = 1'b0;
      ready_nxt  = 1'b0;
      ld         = 1'b0;
      ld_val     = '0;
      unique case (state_r)
         amc_pkg::AMC_POWERUP: begin
            ctl_nxt = CTL_IDLE;
            // timer is zero out of reset, so it must be armed before it is watched
            if (pu_load_r) begin
               ld     = 1'b1;
               ld_val = 18'(POWERUP_CYCLES - 1);
            end else if (tmr_zero) begin
               state_nxt = amc_pkg::AMC_IDLE;
               ready_nxt = 1'b1;
            end
         end
         amc_pkg::AMC_IDLE: begin
            ready_nxt = 1'b1;
            if (req_valid && ready_r) begin
               ready_nxt = 1'b0;
               cur_nxt   = req;
               addr_nxt  = req.addr;
               // all pins switch on one edge: lanes have no skew, address setup zero
               ctl_nxt.chip_sel_n         = 1'b0;
               ctl_nxt.low_lane_select_n  = ~req.lanes[0];
               ctl_nxt.high_lane_select_n = ~req.lanes[1];
               if (req.write) begin
                  ctl_nxt.wr_strobe_n = 1'b0;
                  ctl_nxt.out_en_n    = 1'b1;
                  dq_out_nxt          = req.wdata;
                  dq_oe_nxt           = 1'b1;
                  ld                  = 1'b1;
                  ld_val              = 18'(amc_pkg::CYC_STROBE - 1);
                  state_nxt           = amc_pkg::AMC_WR;
               end else begin
                  ctl_nxt.wr_strobe_n = 1'b1;
                  ctl_nxt.out_en_n    = 1'b0;
                  ld                  = 1'b1;
                  // one extra cycle so the sample lands after full access time
                  ld_val              = 18'(amc_pkg::CYC_ACCESS);
                  state_nxt           = amc_pkg::AMC_RD;
               end
            end
         end
         amc_pkg::AMC_RD: begin
            if (tmr_zero) begin
               rdata_nxt  = mem_dq_in & {{8{cur_r.lanes[1]}}, {8{cur_r.lanes[0]}}};
               rvalid_nxt = 1'b1;
               ctl_nxt    = CTL_IDLE;
               ld         = 1'b1;
               ld_val     = 18'(amc_pkg::CYC_FLOAT - 1);
               state_nxt  = amc_pkg::AMC_FLOAT;
            end
         end
         amc_pkg::AMC_WR: begin
            if (tmr_zero) begin
               // strobe and select end together; data and address still held
               ctl_nxt   = CTL_IDLE;
               ld        = 1'b1;
               ld_val    = 18'(amc_pkg::CYC_RECOVERY - 1);
               state_nxt = amc_pkg::AMC_WREC;
            end
         end
         amc_pkg::AMC_WREC: begin
            if (tmr_zero) begin
               dq_oe_nxt = 1'b0;
               wdone_nxt = 1'b1;
               ld        = 1'b1;
               ld_val    = 18'(amc_pkg::CYC_HIGH - 1);
               state_nxt = amc_pkg::AMC_GAP;
            end
         end
         amc_pkg::AMC_FLOAT: begin
            // wait until device releases the bus before any host drive
            if (tmr_zero) begin
               ld        = 1'b1;
               ld_val    = 18'(amc_pkg::CYC_HIGH - 1);
               state_nxt = amc_pkg::AMC_GAP;
            end
         end
         amc_pkg::AMC_GAP: begin
            if (tmr_zero) begin
               state_nxt = amc_pkg::AMC_IDLE;
               ready_nxt = 1'b1;
            end
         end
         default: begin
            state_nxt = amc_pkg::AMC_IDLE;
            ctl_nxt   = CTL_IDLE;
            dq_oe_nxt = 1'b0;
         end
      endcase
   end

   // pu_load_r is high for the first enabled edge after reset only

   always_ff @(posedge clk) begin
      if (reset) begin
         state_r   <= amc_pkg::AMC_POWERUP;
         ctl_r     <= CTL_IDLE;
         cur_r     <= '0;
         addr_r    <= amc_pkg::ADDR_RST;
         dq_out_r  <= amc_pkg::DATA_RST;
         dq_oe_r   <= 1'b0;
         rdata_r   <= amc_pkg::DATA_RST;
         rvalid_r  <= 1'b0;
         wdone_r   <= 1'b0;
         ready_r   <= 1'b0;
         pu_load_r <= 1'b1;
      end else if (ce) begin
         // ce low freezes timer and pins alike, so every phase only stretches
         state_r   <= state_nxt;
         ctl_r     <= ctl_nxt;
         cur_r     <= cur_nxt;
         addr_r    <= addr_nxt;
         dq_out_r  <= dq_out_nxt;
         dq_oe_r   <= dq_oe_nxt;
         rdata_r   <= rdata_nxt;
         rvalid_r  <= rvalid_nxt;
         wdone_r   <= wdone_nxt;
         ready_r   <= ready_nxt;
         pu_load_r <= 1'b0;
      end
   end

   // limitations of this controller:
   // one access at a time, no page mode with chip select held low
   // every read pays the full select access time
   // select and strobe fall and rise together, so every write is strobe-ended
   // cycle counts assume a 10 ns clock and round each least time up
   // the power-up wait restarts only with reset, not on a supply dip

   assign req_ready  = ready_r;
   assign rd_data    = rdata_r;
   assign rd_valid   = rvalid_r;
   assign wr_done    = wdone_r;
   assign mem_addr   = addr_r;
   assign mem_ctl    = ctl_r;
   assign mem_dq_out = dq_out_r;
   assign mem_dq_oe  = dq_oe_r;
endmodule : amc_host

// File: verif/amc_host_props.sv
// pin timing checker for the mram host controller
`timescale 1ns/1ps
module amc_host_props #(
   parameter int unsigned POWERUP_CYCLES = 4
) (
   input wire logic              clk,
   input wire logic              reset,
   input wire logic              ce,
   input wire amc_pkg::amc_req_t req,
   input wire logic              req_valid,
   input wire logic              req_ready,
   input wire logic [15:0]       rd_data,
   input wire logic              rd_valid,
   input wire logic              wr_done,
   input wire logic [17:0]       mem_addr,
   input wire amc_pkg::amc_ctl_t mem_ctl,
   input wire logic [15:0]       mem_dq_in,
   input wire logic [15:0]       mem_dq_out,
   input wire logic              mem_dq_oe
);
   logic [31:0] pu_r;
   logic [31:0] pu_nxt;
   logic        cs, ws, take;
   assign cs = !mem_ctl.chip_sel_n;
   assign ws = !mem_ctl.wr_strobe_n;
   assign take = ce && req_valid && req_ready;
   // enabled edges since reset, saturating so it cannot wrap
   always_comb pu_nxt = (ce && pu_r < POWERUP_CYCLES) ? pu_r + 1 : pu_r;
   always_ff @(posedge clk) pu_r <= reset ? '0 : pu_nxt;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_read_no_strobe: assert property (cs && !mem_ctl.out_en_n |-> !ws)
      else $error("strobe low in read");
   a_read_sample_late: assert property ($fell(mem_ctl.chip_sel_n) && !ws |=> cs [*3])
      else $error("read select shorter than access");
   a_write_overlap_len: assert property ($rose(cs && ws) |=> cs && ws)
      else $error("write overlap too short");
   a_write_data_setup: assert property ($fell(cs && ws) |-> mem_dq_oe && $past(mem_dq_oe) && $stable(mem_dq_out))
      else $error("write data not set up or held");
   a_write_addr_hold: assert property (cs && ws |=> $stable(mem_addr) [*2])
      else $error("address moved near write");
   a_cs_spacing: assert property ($fell(mem_ctl.chip_sel_n) |=> !$fell(mem_ctl.chip_sel_n) [*3])
      else $error("chip select too close");
   a_powerup_hold: assert property (pu_r < POWERUP_CYCLES |-> !req_ready && !cs && !ws)
      else $error("access before power-up wait");
   a_read_answer: assert property (disable iff (reset || !ce) take && !req.write |-> ##6 rd_valid)
      else $error("read answer late");
   a_write_answer: assert property (take && req.write |-> ##5 (wr_done && !mem_dq_oe))
      else $error("write answer late");
   c_read: cover property (take && !req.write);
   c_write: cover property (take && req.write);
   c_one_lane: cover property (cs && mem_ctl.high_lane_select_n);
   c_frozen_read: cover property (cs && !ws && !ce);
endmodule : amc_host_props
bind amc_host amc_host_props #(.POWERUP_CYCLES(POWERUP_CYCLES)) amc_host_props_inst (.clk(clk), .reset(reset),
   .ce(ce), .req(req), .req_valid(req_valid), .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid),
   .wr_done(wr_done), .mem_addr(mem_addr), .mem_ctl(mem_ctl), .mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out),
   .mem_dq_oe(mem_dq_oe));

// File: verif/amc_mram_model.sv
// behavioural model of the async mram on the far side of the host
`timescale 1ns/1ps
module amc_mram_model #(
   parameter int unsigned ACC_NS = 35
) (
   input  wire logic [17:0]       addr,
   input  wire amc_pkg::amc_ctl_t ctl,
   input  wire logic [15:0]       host_dq,
   output logic [15:0]            dq
);
   logic [15:0] mem [logic [17:0]];
   logic [15:0] wd, m, mw;
   logic [17:0] aw;
   logic        wend, rd, armed;
   time         t_chg;
   assign wend = ctl.chip_sel_n | ctl.wr_strobe_n;
   assign rd = !ctl.chip_sel_n && !ctl.out_en_n && ctl.wr_strobe_n;
   assign m = {{8{!ctl.high_lane_select_n}}, {8{!ctl.low_lane_select_n}}};
   initial armed = 1'b0;
   initial dq = 16'h0000;
   always @(addr or ctl) t_chg = $time;
   // operands latched during the overlap; lanes rise with the strobe
   always @* if (!wend) {armed, aw, wd, mw} = {1'b1, addr, host_dq, m};
   always @(posedge wend) if (armed) begin
      mem[aw] = ((mem.exists(aw) ? mem[aw] : 16'h0000) & ~mw) | (wd & mw);
      armed = 1'b0;
   end
   // a released lane toggles each ns so stale data never reads as good
   always #1 begin
      if (rd && $time - t_chg >= ACC_NS) dq = ((mem.exists(addr) ? mem[addr] : 16'h0000) & m) | (~dq & ~m);
      else if ($time - t_chg >= 3) dq = ~dq;
   end
endmodule : amc_mram_model

// File: verif/amc_host_test.sv
// self-checking bench for the mram host controller
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module amc_host_test;
   localparam int unsigned PU = 16;
   logic              clk, reset, ce, req_valid, req_ready, rd_valid, wr_done, mem_dq_oe;
   amc_pkg::amc_req_t req;
   amc_pkg::amc_ctl_t mem_ctl;
   logic [15:0]       rd_data, mem_dq_in, mem_dq_out, dev_q, got;
   logic [17:0]       mem_addr;
   logic [15:0]       shadow [logic [17:0]];
   int                fails, n_compared;
   assign mem_dq_in = mem_dq_oe ? mem_dq_out : dev_q;
   always #5 clk = ~clk;
   amc_host #(.POWERUP_CYCLES(PU)) amc_host_inst (.clk(clk), .reset(reset), .ce(ce), .req(req),
      .req_valid(req_valid), .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid), .wr_done(wr_done),
      .mem_addr(mem_addr), .mem_ctl(mem_ctl), .mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe));
   amc_mram_model amc_mram_model_inst (.addr(mem_addr), .ctl(mem_ctl), .host_dq(mem_dq_in), .dq(dev_q));
   function automatic logic [15:0] lmask(input logic [1:0] l);
      return {{8{l[1]}}, {8{l[0]}}};
   endfunction : lmask
   task automatic access(input logic wr, input logic [1:0] ln, input logic [17:0] a, input logic [15:0] d);
      int k;
      k = 0;
      while (req_ready !== 1'b1 && k < 50) begin
         @(negedge clk);
         k++;
      end
      req = {wr, ln, a, d};
      req_valid = 1'b1;
      @(negedge clk);
      req_valid = 1'b0;
      k = 0;
      while ((wr ? wr_done : rd_valid) !== 1'b1 && k < 20) begin
         @(negedge clk);
         k++;
      end
      `CHK(k < 20, 1'b1)
      got = rd_data;
      if (wr) begin
         shadow[a] = ((shadow.exists(a) ? shadow[a] : 16'h0000) & ~lmask(ln)) | (d & lmask(ln));
         `CHK(amc_mram_model_inst.mem[a], shadow[a])
      end
   endtask : access
   task automatic t_powerup();
      int k;
      k = 0;
      while (req_ready !== 1'b1 && k < 100) begin
         @(negedge clk);
         k++;
      end
      `CHK(k >= PU, 1'b1)
      `CHK(req_ready, 1'b1)
      $display("t_powerup done");
   endtask : t_powerup
   task automatic t_words();
      logic [17:0] a [3] = '{18'h0_0000, 18'h3_FFFF, 18'h2_AAAA};
      for (int i = 0; i < 3; i++) access(1'b1, 2'b11, a[i], a[i][15:0] ^ 16'hC3A5);
      for (int i = 0; i < 3; i++) begin
         access(1'b0, 2'b11, a[i], 16'h0000);
         `CHK(got, a[i][15:0] ^ 16'hC3A5)
      end
      $display("t_words done");
   endtask : t_words
   task automatic t_lanes();
      access(1'b1, 2'b11, 18'h0_0123, 16'h1234);
      access(1'b1, 2'b01, 18'h0_0123, 16'hFFAB);
      access(1'b1, 2'b10, 18'h0_0123, 16'hCDFF);
      for (int l = 1; l < 4; l++) begin
         access(1'b0, l[1:0], 18'h0_0123, 16'h0000);
         `CHK(got, 16'hCDAB & lmask(l[1:0]))
      end
      $display("t_lanes done");
   endtask : t_lanes
   task automatic t_freeze();
      int k;
      k = 0;
      while (req_ready !== 1'b1 && k < 50) begin
         @(negedge clk);
         k++;
      end
      req = {1'b0, 2'b11, 18'h0_0123, 16'h0000};
      req_valid = 1'b1;
      @(negedge clk);
      req_valid = 1'b0;
      ce = 1'b0;
      repeat (10) @(negedge clk);
      `CHK({mem_ctl.chip_sel_n, rd_valid}, 2'b00)
      `CHK(mem_addr, 18'h0_0123)
      ce = 1'b1;
      k = 0;
      while (rd_valid !== 1'b1 && k < 20) begin
         @(negedge clk);
         k++;
      end
      `CHK(k < 20, 1'b1)
      `CHK(rd_data, 16'hCDAB)
      $display("t_freeze done");
   endtask : t_freeze
   task automatic wrap_up();
      $display("compared %0d mismatched %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up
   initial begin
      {clk, reset, ce, req_valid, req, fails, n_compared} = '0;
      reset = 1'b1;
      ce = 1'b1;
      repeat (8) @(negedge clk);
      reset = 1'b0;
      t_powerup();
      t_words();
      t_lanes();
      t_freeze();
      wrap_up();
   end
   // whole run needs under two hundred cycles
   initial begin
      #50000;
      fails++;
      wrap_up();
   end
endmodule : amc_host_test
